// ==== include/mepi_map.vh ====
// Constants for the PHY-facing pin interface of the 10/100 MAC.
// Assumes the core clock runs at 25 MHz and the includer uses Verilog-2005.
`ifndef MEPI_MAP_VH
`define MEPI_MAP_VH

// Core clock period in nanoseconds.
`define MEPI_CLK_PERIOD_NS      40
// Least high or low phase of the management clock, in nanoseconds.
`define MEPI_MDC_MIN_HALF_NS    160
// Least period of the management clock, in nanoseconds.
`define MEPI_MDC_MIN_PERIOD_NS  400
// Data units per byte: two nibbles in media independent mode, eight bits in serial mode.
`define MEPI_UNITS_MII          4'h2
`define MEPI_UNITS_ENDEC        4'h8
// Depth of each elastic buffer.
`define MEPI_BUF_DEPTH          2

`endif

// ==== logic/mepi_phy_if.v ====
// PHY-facing pin interface: transmit and receive nibble paths, carrier and
// collision monitors, management clock and management data pin.
// Assumes PHY clocks much slower than core_clk (sampled, edge-detected) and
// that mode inputs are static while a frame is in flight.
`timescale 1ns/1ps
`include "mepi_map.vh"

// Small elastic buffer with valid and ready on both sides.
module mepi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `MEPI_BUF_DEPTH
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];  // Storage words.
    reg [AW-1:0]    wr_ptr_reg;           // Next slot to fill.
    reg [AW-1:0]    rd_ptr_reg;           // Oldest slot.
    reg [AW:0]      count_reg;            // Words held.

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];

    // Pointers wrap at DEPTH so any depth works, not only powers of two.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Storage has no reset; contents are only read while counted valid.
    always @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule // mepi_fifo

// Overview of operation
// [RL1] PHY supplies continuous transmit clock.
// [RL2] Transmit enable high, changes on transmit clock.
// [RL3] Enable rises with first preamble nibble.
// [RL4] Enable drops right after last nibble.
// [RL5] One valid nibble per enabled clock.
// [RL6] PHY ignores data while enable low.
// [RL7] Serial mode transmits on bit zero only.
// [RL8] PHY supplies continuous receive clock.
// [RL9] Receive valid high across whole frame.
// [RL10] Receive valid falls after final nibble.
// [RL11] Capture nibble per clock while valid.
// [RL12] Serial mode receives on bit zero only.
// [RL13] Receive error marks current frame errored.
// [RL14] Receive error ignored while valid low.
// [RL15] Serial mode keeps receive error low.
// [RL16] PHY drives carrier sense for busy medium.
// [RL17] Synchronise carrier and collision before use.
// [RL18] PHY holds collision high during collision.
// [RL19] Full duplex ignores collision input.
// [RL20] MAC generates the management clock.
// [RL21] Management phases 160ns, period 400ns minimum.
// [RL22] Management data moves on management clock.
// [RL23] Bytes as nibbles, low nibble first.
module mepi_phy_if (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       endec_mode,
    input  wire       full_duplex,
    input  wire [7:0] tx_byte,
    input  wire       tx_byte_last,
    input  wire       tx_byte_valid,
    output wire       tx_byte_ready,
    input  wire       tx_clk,
    output reg        tx_en,
    output reg  [3:0] txd,
    input  wire       rx_clk,
    input  wire       rx_dv,
    input  wire       rx_er,
    input  wire [3:0] rxd,
    output wire [7:0] rx_byte,
    output wire       rx_byte_last,
    output wire       rx_byte_err,
    output wire       rx_byte_valid,
    input  wire       rx_byte_ready,
    output reg        rx_overflow,
    input  wire       crs,
    input  wire       col,
    output wire       carrier_sense,
    output wire       collision,
    output reg        mdc,
    input  wire       mdio_in,
    output reg        mdio_out,
    output reg        mdio_oe,
    input  wire       mgmt_out_bit,
    input  wire       mgmt_drive,
    output reg        mgmt_in_bit,
    output reg        mgmt_shift,
    output reg        mgmt_sample
);
    // Management clock half period: the larger of the two least figures, rounded up.
    localparam HALF_A   = (`MEPI_MDC_MIN_HALF_NS + `MEPI_CLK_PERIOD_NS - 1) / `MEPI_CLK_PERIOD_NS;
    localparam HALF_B   = (`MEPI_MDC_MIN_PERIOD_NS + 2 * `MEPI_CLK_PERIOD_NS - 1) / (2 * `MEPI_CLK_PERIOD_NS);
    localparam MDC_HALF = (HALF_A > HALF_B) ? HALF_A : HALF_B;

    // Two-flop synchronisers for every pin from outside the core domain.
    reg [1:0] txc_s_reg;     // Transmit clock samples.
    reg       txc_d_reg;     // Transmit clock, one more stage for edge detection.
    reg [1:0] rxc_s_reg;     // Receive clock samples.
    reg       rxc_d_reg;     // Receive clock, delayed copy.
    reg [1:0] dv_s_reg;      // Receive data valid.
    reg [1:0] er_s_reg;      // Receive error.
    reg [3:0] rxd_s1_reg;    // Receive data, first stage.
    reg [3:0] rxd_s2_reg;    // Receive data, second stage.
    reg [1:0] crs_s_reg;     // Carrier sense.
    reg [1:0] col_s_reg;     // Collision.
    reg [1:0] mdi_s_reg;     // Management data in.

    // The first stage of each chain feeds only the second stage.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txc_s_reg  <= 2'h0;
            txc_d_reg  <= 1'b0;
            rxc_s_reg  <= 2'h0;
            rxc_d_reg  <= 1'b0;
            dv_s_reg   <= 2'h0;
            er_s_reg   <= 2'h0;
            rxd_s1_reg <= 4'h0;
            rxd_s2_reg <= 4'h0;
            crs_s_reg  <= 2'h0;
            col_s_reg  <= 2'h0;
            mdi_s_reg  <= 2'h0;
        end else begin
            txc_s_reg  <= {txc_s_reg[0], tx_clk};
            txc_d_reg  <= txc_s_reg[1];
            rxc_s_reg  <= {rxc_s_reg[0], rx_clk};
            rxc_d_reg  <= rxc_s_reg[1];
            dv_s_reg   <= {dv_s_reg[0], rx_dv};
            er_s_reg   <= {er_s_reg[0], rx_er};
            rxd_s1_reg <= rxd;
            rxd_s2_reg <= rxd_s1_reg;
            crs_s_reg  <= {crs_s_reg[0], crs};   // RL17
            col_s_reg  <= {col_s_reg[0], col};   // RL17
            mdi_s_reg  <= {mdi_s_reg[0], mdio_in};
        end
    end

    // Edge strobes, one core cycle each.
    wire tx_rise = txc_s_reg[1] & ~txc_d_reg;
    wire rx_fall = ~rxc_s_reg[1] & rxc_d_reg;

    assign carrier_sense = crs_s_reg[1];
    assign collision     = col_s_reg[1] & ~full_duplex;  // RL19

    wire [3:0] units = endec_mode ? `MEPI_UNITS_ENDEC : `MEPI_UNITS_MII;

    // Transmit side: the buffer lets the user run ahead of the slow link.
    wire       txq_valid;
    wire [8:0] txq_data;
    reg  [7:0] tx_sh_reg;     // Bits of the byte not yet sent.
    reg  [3:0] tx_left_reg;   // Units of the byte still to send.
    reg        tx_last_reg;   // Byte on the wire closes a frame.
    reg        tx_gap_reg;    // Forces one idle period between frames.
    wire       txq_pop = tx_rise & (tx_left_reg == 4'h0) & ~tx_gap_reg & txq_valid;

    mepi_fifo #(.WIDTH(9), .DEPTH(`MEPI_BUF_DEPTH)) tx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (tx_byte_valid),
        .in_ready  (tx_byte_ready),
        .in_data   ({tx_byte_last, tx_byte}),
        .out_valid (txq_valid),
        .out_ready (txq_pop),
        .out_data  (txq_data)
    );

    // Outputs change just after a transmit clock rise, so the PHY sees them stable at the next.
    // A starved buffer mid-frame ends the frame early; the user must keep it fed.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_en       <= 1'b0;
            txd         <= 4'h0;
            tx_sh_reg   <= 8'h00;
            tx_left_reg <= 4'h0;
            tx_last_reg <= 1'b0;
            tx_gap_reg  <= 1'b0;
        end else if (tx_rise) begin                                           // RL2
            if (tx_left_reg != 4'h0) begin
                // Next nibble or bit of the current byte, low end first.
                txd         <= endec_mode ? {3'h0, tx_sh_reg[0]} : tx_sh_reg[3:0];   // RL5 RL7 RL23
                tx_sh_reg   <= endec_mode ? {1'b0, tx_sh_reg[7:1]} : {4'h0, tx_sh_reg[7:4]};
                tx_left_reg <= tx_left_reg - 4'h1;
                tx_en       <= 1'b1;                                          // RL3
                tx_gap_reg  <= (tx_left_reg == 4'h1) & tx_last_reg;
            end else if (tx_gap_reg) begin
                // Frame done: enable drops at the period after the final nibble.
                tx_en      <= 1'b0;                                           // RL4
                txd        <= 4'h0;
                tx_gap_reg <= 1'b0;
            end else if (txq_valid) begin
                // First unit of a fresh byte; the preamble is the user's first bytes.
                txd         <= endec_mode ? {3'h0, txq_data[0]} : txq_data[3:0];     // RL7 RL23
                tx_sh_reg   <= endec_mode ? {1'b0, txq_data[7:1]} : {4'h0, txq_data[7:4]};
                tx_left_reg <= units - 4'h1;
                tx_last_reg <= txq_data[8];
                tx_en       <= 1'b1;                                          // RL3
                tx_gap_reg  <= (units == 4'h1) & txq_data[8];
            end else begin
                tx_en <= 1'b0;                                                // RL4
                txd   <= 4'h0;
            end
        end
    end

    // Receive side: sampled at the receive clock fall, mid-period, when data is settled.
    reg  [7:0] rx_acc_reg;    // Byte being assembled.
    reg  [3:0] rx_cnt_reg;    // Units gathered into it.
    reg        rx_frame_reg;  // Frame in progress.
    reg        rx_err_reg;    // Frame marked errored.
    reg        rx_pend_reg;   // A finished byte waits to learn if it is last.
    reg  [7:0] rx_pend_data;  // That byte.
    reg        rx_push_reg;   // One-cycle push into the buffer.
    reg  [9:0] rx_push_data;  // {err, last, byte}.
    wire       rxq_ready;
    wire [9:0] rxq_data;
    wire       er_in    = er_s_reg[1] & dv_s_reg[1];                          // RL14
    wire       err_now  = (rx_frame_reg & rx_err_reg) | er_in;                // RL13
    wire [7:0] acc_next = endec_mode ? {rxd_s2_reg[0], rx_acc_reg[7:1]}       // RL12
                                     : {rxd_s2_reg, rx_acc_reg[7:4]};        // RL23

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_acc_reg   <= 8'h00;
            rx_cnt_reg   <= 4'h0;
            rx_frame_reg <= 1'b0;
            rx_err_reg   <= 1'b0;
            rx_pend_reg  <= 1'b0;
            rx_pend_data <= 8'h00;
            rx_push_reg  <= 1'b0;
            rx_push_data <= 10'h000;
            rx_overflow  <= 1'b0;
        end else begin
            rx_push_reg <= 1'b0;
            rx_overflow <= rx_push_reg & ~rxq_ready;
            if (rx_fall) begin
                if (dv_s_reg[1]) begin
                    // Valid period: gather one unit.
                    rx_frame_reg <= 1'b1;                                     // RL11
                    rx_err_reg   <= err_now;
                    rx_acc_reg   <= acc_next;
                    if (rx_cnt_reg == units - 4'h1) begin
                        rx_cnt_reg   <= 4'h0;
                        rx_pend_reg  <= 1'b1;
                        rx_pend_data <= acc_next;
                        if (rx_pend_reg) begin
                            rx_push_reg  <= 1'b1;
                            rx_push_data <= {err_now, 1'b0, rx_pend_data};
                        end
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                    end
                end else begin
                    // Valid low closes the frame; data lines and a stray odd nibble are ignored.
                    rx_frame_reg <= 1'b0;                                     // RL11 RL14
                    rx_cnt_reg   <= 4'h0;
                    rx_pend_reg  <= 1'b0;
                    if (rx_pend_reg) begin
                        rx_push_reg  <= 1'b1;
                        rx_push_data <= {rx_err_reg, 1'b1, rx_pend_data};     // RL13
                    end
                end
            end
        end
    end

    // The PHY cannot be stalled; the buffer absorbs receiver stalls, overflow is flagged.
    mepi_fifo #(.WIDTH(10), .DEPTH(`MEPI_BUF_DEPTH)) rx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (rx_push_reg),
        .in_ready  (rxq_ready),
        .in_data   (rx_push_data),
        .out_valid (rx_byte_valid),
        .out_ready (rx_byte_ready),
        .out_data  (rxq_data)
    );
    assign rx_byte      = rxq_data[7:0];
    assign rx_byte_last = rxq_data[8];
    assign rx_byte_err  = rxq_data[9];

    // Management clock divider, free running and independent of the link clocks.
    reg [7:0] mdc_cnt_reg;   // Cycles already spent in the current phase.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mdc_cnt_reg <= 8'h00;
            mdc         <= 1'b0;
            mdio_out    <= 1'b0;
            mdio_oe     <= 1'b0;
            mgmt_in_bit <= 1'b0;
            mgmt_shift  <= 1'b0;
            mgmt_sample <= 1'b0;
        end else begin
            mgmt_shift  <= 1'b0;
            mgmt_sample <= 1'b0;
            if (mdc_cnt_reg == MDC_HALF[7:0] - 8'h01) begin
                mdc_cnt_reg <= 8'h00;
                mdc         <= ~mdc;                                          // RL20 RL21
                if (mdc) begin
                    // Falling edge: launch the next written bit.
                    mdio_out   <= mgmt_out_bit;                               // RL22
                    mdio_oe    <= mgmt_drive;
                    mgmt_shift <= 1'b1;
                end else begin
                    // Rising edge: take the bit the PHY drives.
                    mgmt_in_bit <= mdi_s_reg[1];                              // RL22
                    mgmt_sample <= 1'b1;
                end
            end else begin
                mdc_cnt_reg <= mdc_cnt_reg + 8'h01;
            end
        end
    end
endmodule // mepi_phy_if

// ==== test/mepi_phy_model.sv ====
// PHY model: free-running 320 ns link clocks, transmit capture, frame source.
// Assumes the bench calls rx_frame and reads cap only between frames.
`timescale 1ns/1ps
module mepi_phy_model (
    input  wire       endec,
    input  wire       tx_en,
    input  wire [3:0] txd,
    output reg        tx_clk,
    output reg        rx_clk,
    output reg        rx_dv,
    output reg        rx_er,
    output reg  [3:0] rxd
);
    logic [3:0] cap[$]; // Units seen while enable was high.
    bit         busy;   // High while a frame is being sent.
    // Both clocks run continuously; the receive one is offset so phases differ.
    initial begin
        tx_clk = 1'b0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = 4'h0;
        rx_clk = 1'b0;
        #37;
        forever #160 rx_clk = ~rx_clk;
    end
    always #160 tx_clk = ~tx_clk;
    // Data is only taken in periods where enable is high.
    always @(posedge tx_clk) if (tx_en) cap.push_back(txd);
    // Idle data lines never hold the last value, nor does the error line outside serial mode, so a design that samples them shows it.
    always @(posedge rx_clk) if (!busy) begin
        #1;
        rxd = ~rxd;
        rx_er = ~rx_er & ~endec;
    end
    // Send nb bytes, low nibble or bit 0 first; errn marks one errored unit.
    task automatic rx_frame(input logic [23:0] b, input int nb, input int errn);
        int i;
        busy = 1;
        for (i = 0; i < (endec ? nb * 8 : nb * 2); i++) begin
            @(posedge rx_clk);
            #1;
            rxd = endec ? {3'h5, b[i]} : b[i*4 +: 4];
            rx_dv = 1'b1;
            rx_er = (i == errn);
        end
        @(posedge rx_clk);
        #1;
        rx_dv = 1'b0;
        busy = 0;
    endtask
endmodule // mepi_phy_model

// ==== test/mepi_phy_if_props.sv ====
// Checker: management clock timing, synchronisers, transmit timing, buffer hold.
// Assumes it is bound to mepi_phy_if and sees only its ports.
`timescale 1ns/1ps
module mepi_phy_if_props (
    input wire       core_clk,
    input wire       rst,
    input wire       endec_mode,
    input wire       full_duplex,
    input wire       tx_clk,
    input wire       tx_en,
    input wire [3:0] txd,
    input wire [7:0] rx_byte,
    input wire       rx_byte_valid,
    input wire       rx_byte_ready,
    input wire       crs,
    input wire       col,
    input wire       carrier_sense,
    input wire       collision,
    input wire       mdc,
    input wire       mdio_oe,
    input wire       mgmt_sample
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Each management clock phase lasts five core cycles, 200 ns.
    sequence s_mdc_high; mdc [*5] ##1 !mdc; endsequence
    sequence s_mdc_low; !mdc [*5] ##1 mdc; endsequence
    a_mdc_high_phase: assert property ($rose(mdc) |-> s_mdc_high) else $error("mdc high phase wrong");
    a_mdc_low_phase: assert property ($fell(mdc) |-> s_mdc_low) else $error("mdc low phase wrong");
    a_sample_at_rise: assert property (mgmt_sample |-> $rose(mdc)) else $error("mdio sampled off rise");
    a_oe_at_fall: assert property ($changed(mdio_oe) |-> $fell(mdc)) else $error("mdio enable moved off fall");
    // Two flops stand between the pins and the outputs.
    a_crs_two_flops: assert property (!$past(rst) && !$past(rst, 2) |-> carrier_sense == $past(crs, 2))
        else $error("carrier sense latency wrong");
    a_col_two_flops: assert property (!$past(rst) && !$past(rst, 2) |-> collision == ($past(col, 2) && !full_duplex))
        else $error("collision latency wrong");
    a_duplex_no_col: assert property (full_duplex |-> !collision) else $error("collision seen in full duplex");
    // Outputs may only move shortly after a sampled transmit clock rise.
    a_tx_on_link: assert property ($changed(tx_en) || (tx_en && $changed(txd)) |-> $past(tx_clk, 2))
        else $error("transmit outputs moved off link clock");
    a_serial_upper: assert property (endec_mode |-> txd[3:1] == 3'h0) else $error("serial upper bits used");
    a_rx_word_hold: assert property (rx_byte_valid && !rx_byte_ready |=> rx_byte_valid && $stable(rx_byte))
        else $error("stalled word changed");
endmodule // mepi_phy_if_props
bind mepi_phy_if mepi_phy_if_props mepi_phy_if_props_i (.core_clk, .rst, .endec_mode, .full_duplex, .tx_clk,
    .tx_en, .txd, .rx_byte, .rx_byte_valid, .rx_byte_ready, .crs, .col, .carrier_sense, .collision, .mdc,
    .mdio_oe, .mgmt_sample);

// ==== test/mepi_phy_if_tb.sv ====
// Bench: frame table in both modes, then stall, carrier, management, reset.
// Assumes mepi_phy_model as far side and the bound checker.
`timescale 1ns/1ps
module mepi_phy_if_tb;
    typedef struct { logic endec; int nb; logic [23:0] b; int errn; } mepi_row_t;
    logic       core_clk, rst, endec_mode, full_duplex, tx_byte_last, tx_byte_valid, rx_byte_ready;
    logic [7:0] tx_byte;
    logic       crs, col, phy_mdio, mgmt_out_bit, mgmt_drive, ovf_seen, refused, stall;
    wire        tx_byte_ready, tx_clk, tx_en, rx_clk, rx_dv, rx_er, rx_byte_last, rx_byte_err, rx_byte_valid;
    wire        rx_overflow, carrier_sense, collision, mdc, mdio_in, mdio_out, mdio_oe;
    wire        mgmt_in_bit, mgmt_shift, mgmt_sample;
    wire  [3:0] txd, rxd;
    wire  [7:0] rx_byte;
    int         miscompares, checks_done, i, w;
    realtime    t0;
    logic [9:0] got[$]; // Received {err, last, byte} words.
    // Ordinary cases: mode, byte count, bytes (first in the low byte), errored unit.
    mepi_row_t rows[4] = '{'{1'b0, 2, 24'h00d555, -1}, '{1'b0, 3, 24'h0fa35d, 0},
                           '{1'b1, 2, 24'h00c35d, -1}, '{1'b1, 3, 24'h01a5ff, -1}};
    // The shared pin carries the MAC's bit while it drives, else the PHY's.
    assign mdio_in = (mdio_oe === 1'b1) ? mdio_out : phy_mdio;
    mepi_phy_if mepi_phy_if_i (.core_clk, .rst, .endec_mode, .full_duplex, .tx_byte, .tx_byte_last,
        .tx_byte_valid, .tx_byte_ready, .tx_clk, .tx_en, .txd, .rx_clk, .rx_dv, .rx_er, .rxd, .rx_byte,
        .rx_byte_last, .rx_byte_err, .rx_byte_valid, .rx_byte_ready, .rx_overflow, .crs, .col, .carrier_sense,
        .collision, .mdc, .mdio_in, .mdio_out, .mdio_oe, .mgmt_out_bit, .mgmt_drive, .mgmt_in_bit,
        .mgmt_shift, .mgmt_sample);
    mepi_phy_model mepi_phy_model_i (.endec(endec_mode), .tx_en, .txd, .tx_clk, .rx_clk, .rx_dv, .rx_er, .rxd);
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    // Consumer: ready is set first so the recorded transfer is the one the next edge takes.
    always @(negedge core_clk) begin
        rx_byte_ready = !stall;
        if (rx_byte_valid === 1'b1 && rx_byte_ready) got.push_back({rx_byte_err, rx_byte_last, rx_byte});
        if (rx_overflow === 1'b1) ovf_seen = 1'b1;
        if (tx_byte_ready === 1'b0) refused = 1'b1;
    end
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Offer one byte and hold it until an edge with ready takes it; valid stays up.
    task automatic tx_put(input logic [7:0] b, input logic last);
        int n;
        @(negedge core_clk);
        tx_byte = b;
        tx_byte_last = last;
        tx_byte_valid = 1'b1;
        for (n = 0; n < 200 && tx_byte_ready !== 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
    endtask
    task automatic run_row(input mepi_row_t r);
        int k;
        int n;
        @(negedge core_clk);
        endec_mode = r.endec;
        mepi_phy_model_i.cap.delete();
        got.delete();
        for (k = 0; k < r.nb; k++) tx_put(r.b[k*8 +: 8], k == r.nb - 1);
        @(negedge core_clk);
        tx_byte_valid = 1'b0;
        for (k = 0; k < 900 && tx_en !== 1'b1; k++) @(negedge core_clk);
        for (k = 0; k < 900 && tx_en !== 1'b0; k++) @(negedge core_clk);
        n = r.endec ? r.nb * 8 : r.nb * 2;
        chk("tx unit count", n, mepi_phy_model_i.cap.size());
        for (k = 0; k < n; k++)
            chk("txd", r.endec ? {3'h0, r.b[k]} : r.b[k*4 +: 4], mepi_phy_model_i.cap[k]);
        mepi_phy_model_i.rx_frame(r.b, r.nb, r.errn);
        for (k = 0; k < 100 && got.size() < r.nb; k++) @(negedge core_clk);
        for (k = 0; k < r.nb; k++)
            chk("rx word", {r.errn >= 0, k == r.nb - 1, r.b[k*8 +: 8]}, got[k]);
        $display("row done: serial %0d, bytes %0d", r.endec, r.nb);
    endtask
    // Limit of 50000 cycles, many times the expected run of about 1250.
    initial begin
        #2000000;
        miscompares++;
        results();
    end
    initial begin
        {rst, endec_mode, full_duplex, tx_byte_last, tx_byte_valid, crs, col, phy_mdio} = 8'hff;
        {endec_mode, full_duplex, tx_byte_last, tx_byte_valid, crs, col, phy_mdio} = 7'h00;
        {mgmt_out_bit, mgmt_drive, ovf_seen, refused, stall, rx_byte_ready} = 6'h00;
        tx_byte = 8'h00;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        for (i = 0; i < 4; i++) run_row(rows[i]);
        chk("tx refusal seen", 1, refused);
        // Stalled consumer: two words are held, the third is refused and flagged.
        got.delete();
        endec_mode = 1'b0;
        stall = 1'b1;
        mepi_phy_model_i.rx_frame(24'h332211, 3, -1);
        repeat (40) @(negedge core_clk);
        chk("overflow flag", 1, ovf_seen);
        stall = 1'b0;
        repeat (10) @(negedge core_clk);
        chk("held words", 2, got.size());
        chk("held word 0", 10'h011, got[0]);
        chk("held word 1", 10'h022, got[1]);
        $display("stall test done");
        // Every carrier, collision and duplex combination.
        for (i = 0; i < 8; i++) begin
            {crs, col, full_duplex} = i[2:0];
            repeat (3) @(negedge core_clk);
            chk("carrier", crs, carrier_sense);
            chk("collision", col & ~full_duplex, collision);
        end
        $display("carrier test done");
        @(posedge mdc) t0 = $realtime;
        @(posedge mdc);
        chk("mdc period cycles", 10, ($realtime - t0) / 40.0);
        @(negedge core_clk);
        {mgmt_drive, mgmt_out_bit} = 2'h3;
        for (w = 0; w < 30 && mgmt_shift !== 1'b1; w++) @(negedge core_clk);
        @(negedge core_clk);
        chk("mdio drive", 2'h3, {mdio_oe, mdio_out});
        // The PHY drives the opposite of the last bit taken, so a stuck sample path shows.
        {mgmt_drive, phy_mdio} = 2'h0;
        repeat (24) @(negedge core_clk);
        for (w = 0; w < 30 && mgmt_sample !== 1'b1; w++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        chk("mdio read", 2'h0, {mdio_oe, mgmt_in_bit});
        $display("management test done");
        // Reset in mid-frame clears tx_en and rx_byte_valid and leaves tx_byte_ready high; a clean frame follows.
        tx_put(8'h55, 1'b0);
        @(negedge core_clk) tx_byte_valid = 1'b0;
        for (w = 0; w < 30 && tx_en !== 1'b1; w++) @(negedge core_clk);
        {rst, tx_byte_valid} = 2'h2;
        repeat (3) @(negedge core_clk);
        chk("reset outputs", 3'h1, {tx_en, rx_byte_valid, tx_byte_ready});
        rst = 1'b0;
        run_row(rows[0]);
        $display("reset test done");
        results();
    end
endmodule // mepi_phy_if_tb
